// >>> hw/msr_pkg.sv
// Package for the core special-function register bank: addresses, fields, carriers
package msr_pkg;
    // Special-function register addresses in the data space
    localparam logic [7:0] ADDR_PTR_ZERO_PORT = 8'h00;
    localparam logic [7:0] ADDR_POINTER_ZERO = 8'h01;
    localparam logic [7:0] ADDR_PTR_ONE_PORT = 8'h02;
    localparam logic [7:0] ADDR_POINTER_ONE = 8'h03;
    localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
    localparam logic [7:0] ADDR_PC_LOW = 8'h06;
    localparam logic [7:0] ADDR_STATUS = 8'h0A;
    localparam logic [7:0] ADDR_PORT_DIR = 8'h11;
    localparam logic [7:0] ADDR_SYS_SYSTEM_CONTROL_ZERO = 8'h1A;
    // Special-function area ends below this address; general RAM lies above
    localparam logic [7:0] ADDR_GP_START = 8'h80;

    // Bank select field layout
    localparam logic [7:0] BANK_MASK_SMALL = 8'h23;
    localparam logic [7:0] BANK_MASK_LARGE = 8'h67;
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam int DBANK_LSB = 0;
    localparam int PBANK_LSB = 5;

    // Status bit positions
    localparam int ST_CARRY = 0;
    localparam int ST_HALF = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_WRAP = 3;
    localparam int ST_SLEEP = 4;
    localparam int ST_DOG = 5;
    localparam logic [7:0] STATUS_SW_MASK = 8'h0F;

    // System control zero bit positions
    localparam int CT_CLKSEL = 0;
    localparam int CT_XTLP = 1;
    localparam int CT_DIVPIN = 2;
    localparam int CT_PWM0 = 3;
    localparam int CT_PWM1 = 4;
    localparam int CT_SPLIT = 5;
    localparam int CT_DIVSRC = 6;
    localparam int CT_REMAP = 7;
    localparam logic [7:0] SYSTEM_CONTROL_ZERO_RESET = 8'h00;
    localparam logic [7:0] PORT_DIR_RESET = 8'hFF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] PC_PAGE_RESET = 8'h00;

    // Register access from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } msr_acc_s;

    // Flag results of the ALU for the current instruction
    typedef struct packed {
        logic upd;
        logic carry;
        logic half;
        logic wrap;
        logic zero;
        logic rot;
        logic rotCarry;
    } msr_alu_s;

    // Resolved data-memory access
    typedef struct packed {
        logic [2:0] bank;
        logic [7:0] addr;
        logic isSfr;
    } msr_mem_s;
endpackage : msr_pkg

// >>> hw/msr_core_regs.sv
// Core special-function registers: banking, status flags, direction, system control zero
`timescale 1ns/1ns
module msr_core_regs
    import msr_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, low active
    input wire logic clkEn, // Freezes all state when low
    input wire logic powerUp, // Power-on reset in progress
    input wire logic dogSleepReset, // Reset is a watchdog expiry in idle or sleep
    input wire logic dogExpiry, // Watchdog time-out event
    input wire logic dogKick, // Watchdog-clear instruction executed
    input wire logic haltExec, // Halt instruction executed
    input wire msr_pkg::msr_acc_s acc, // Register read and write access
    input wire logic accIndirect, // Access uses a pointer port
    input wire msr_pkg::msr_alu_s alu, // ALU flag results
    output logic [7:0] rdata_q, // Read data, one cycle after rd
    output logic pcLoad_q, // Program counter low loaded
    output logic [7:0] pcLow_q, // New program counter low byte
    output logic dummyCycle_q, // Inserted dummy cycle after jump
    output msr_pkg::msr_mem_s memSel_q, // Resolved data memory access
    output logic [1:0] codeBank_q, // Program bank selection
    output logic [7:0] status_q, // Status register image
    output logic [7:0] portInput_q, // Direction: one means input
    output logic [7:0] sysCtrl_q // System control zero outputs
);
    import msr_pkg::*;

    logic [7:0] bankMask;
    logic [7:0] bankSel_q;
    logic [7:0] pointerZero_q;
    logic [7:0] pointerOne_q;
    logic [3:0] statusFlags_q;
    logic dogFlag_q;
    logic sleepFlag_q;
    logic [7:0] dirReg_q;
    logic [7:0] ctrlReg_q;
    logic wrBank;
    logic wrStatus;
    logic wrDir;
    logic [7:0] statusView;
    logic [7:0] readMux;

    assign bankMask = LARGE_VARIANT ? BANK_MASK_LARGE : BANK_MASK_SMALL;
    assign wrBank = acc.wr && acc.addr == ADDR_BANK_SELECT && !accIndirect;
    assign wrStatus = acc.wr && acc.addr == ADDR_STATUS && !accIndirect;
    assign wrDir = acc.wr && acc.addr == ADDR_PORT_DIR && !accIndirect;

    // Bank selection; a watchdog reset while asleep keeps it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            if (!dogSleepReset || powerUp) begin
                bankSel_q <= BANK_RESET;
            end
        end else if (clkEn && wrBank) begin
            bankSel_q <= acc.wdata & bankMask;
        end
    end

    // Memory pointers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pointerZero_q <= ZERO_BYTE;
            pointerOne_q <= ZERO_BYTE;
        end else if (clkEn && acc.wr && !accIndirect) begin
            if (acc.addr == ADDR_POINTER_ZERO) begin
                pointerZero_q <= acc.wdata;
            end else if (acc.addr == ADDR_POINTER_ONE) begin
                pointerOne_q <= acc.wdata;
            end
        end
    end

    // Arithmetic flags: no reset value, they power up undefined
    always_ff @(posedge clk) begin
        if (clkEn && rst_n) begin
            if (alu.upd) begin
                statusFlags_q[ST_WRAP] <= alu.wrap;
                statusFlags_q[ST_ZERO] <= alu.zero;
                statusFlags_q[ST_HALF] <= alu.half;
                statusFlags_q[ST_CARRY] <= alu.carry;
            end else if (alu.rot) begin
                statusFlags_q[ST_CARRY] <= alu.rotCarry;
            end else if (wrStatus) begin
                statusFlags_q[3:0] <= acc.wdata[3:0];
            end
        end
    end
    // Dog flag: expiry wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n && powerUp) begin
            dogFlag_q <= 1'b0;
        end else if (clkEn && rst_n) begin
            if (dogExpiry) begin
                dogFlag_q <= 1'b1;
            end else if (dogKick || haltExec) begin
                dogFlag_q <= 1'b0;
            end
        end
    end

    // Sleep flag; status writes are ignored for both protected flags
    always_ff @(posedge clk) begin
        if (!rst_n && powerUp) begin
            sleepFlag_q <= 1'b0;
        end else if (clkEn && rst_n) begin
            if (haltExec) begin
                sleepFlag_q <= 1'b1;
            end else if (dogKick) begin
                sleepFlag_q <= 1'b0;
            end
        end
    end

    // Status is never pushed by this block on calls or interrupts
    assign statusView = {2'b00, dogFlag_q, sleepFlag_q, statusFlags_q[3:0]};

    // One flop per pin so each direction bit stands on its own
    for (genvar g = 0; g < $bits(dirReg_q); g++) begin : g_dir
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                dirReg_q[g] <= PORT_DIR_RESET[g];
            end else if (clkEn && wrDir) begin
                dirReg_q[g] <= acc.wdata[g];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrlReg_q <= SYSTEM_CONTROL_ZERO_RESET;
        end else if (clkEn && acc.wr && !accIndirect && acc.addr == ADDR_SYS_SYSTEM_CONTROL_ZERO) begin
            ctrlReg_q <= acc.wdata;
        end
    end

    // Program counter low write: jump inside page plus one dummy cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pcLoad_q <= 1'b0;
            pcLow_q <= PC_PAGE_RESET;
            dummyCycle_q <= 1'b0;
        end else if (clkEn) begin
            pcLoad_q <= acc.wr && !accIndirect && acc.addr == ADDR_PC_LOW;
            dummyCycle_q <= pcLoad_q;
            if (acc.wr && !accIndirect && acc.addr == ADDR_PC_LOW) begin
                pcLow_q <= acc.wdata;
            end
        end
    end

    // Address resolution for data memory
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            memSel_q <= '0;
        end else if (clkEn) begin
            if (accIndirect && acc.addr == ADDR_PTR_ZERO_PORT) begin
                memSel_q.bank <= 3'd0;
                memSel_q.addr <= pointerZero_q;
                memSel_q.isSfr <= pointerZero_q < ADDR_GP_START;
            end else if (accIndirect && acc.addr == ADDR_PTR_ONE_PORT) begin
                memSel_q.bank <= bankSel_q[DBANK_LSB +: 3];
                memSel_q.addr <= pointerOne_q;
                memSel_q.isSfr <= pointerOne_q < ADDR_GP_START;
            end else begin
                memSel_q.bank <= 3'd0;
                memSel_q.addr <= acc.addr;
                memSel_q.isSfr <= acc.addr < ADDR_GP_START;
            end
        end
    end

    // Register read mux; unused addresses and pointer ports read zero
    always_comb begin
        readMux = ZERO_BYTE;
        if (accIndirect) begin
            readMux = ZERO_BYTE;
        end else if (acc.addr == ADDR_POINTER_ZERO) begin
            readMux = pointerZero_q;
        end else if (acc.addr == ADDR_POINTER_ONE) begin
            readMux = pointerOne_q;
        end else if (acc.addr == ADDR_BANK_SELECT) begin
            readMux = bankSel_q & bankMask;
        end else if (acc.addr == ADDR_PC_LOW) begin
            readMux = pcLow_q;
        end else if (acc.addr == ADDR_STATUS) begin
            readMux = statusView;
        end else if (acc.addr == ADDR_PORT_DIR) begin
            readMux = dirReg_q;
        end else if (acc.addr == ADDR_SYS_SYSTEM_CONTROL_ZERO) begin
            readMux = ctrlReg_q;
        end
    end

    // Outputs are plain flops; images lag their working register by one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= ZERO_BYTE;
        end else if (clkEn && acc.rd) begin
            rdata_q <= readMux;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            codeBank_q <= 2'b00;
        end else if (clkEn) begin
            codeBank_q <= bankSel_q[PBANK_LSB +: 2] & bankMask[PBANK_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_q <= ZERO_BYTE;
        end else if (clkEn) begin
            status_q <= statusView;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            portInput_q <= PORT_DIR_RESET;
        end else if (clkEn) begin
            portInput_q <= dirReg_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sysCtrl_q <= SYSTEM_CONTROL_ZERO_RESET;
        end else if (clkEn) begin
            sysCtrl_q <= ctrlReg_q;
        end
    end

    // Assertions
    sequence s_pc_write;
        clkEn && acc.wr && !accIndirect && acc.addr == ADDR_PC_LOW;
    endsequence
    sequence s_jump_then_dummy;
        pcLoad_q ##1 dummyCycle_q;
    endsequence
    sequence s_power_or_plain_reset;
        !rst_n && (powerUp || !dogSleepReset);
    endsequence
    sequence s_sleep_dog_reset;
        !rst_n && dogSleepReset && !powerUp;
    endsequence
    sequence s_bank_write_seen;
        clkEn && wrBank ##1 clkEn;
    endsequence

    a_dummy_follows_jump: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && pcLoad_q |=> dummyCycle_q)
        else $error("dummy cycle missing after pc write");
    a_pc_jump_dummy: assert property (@(posedge clk) disable iff (!rst_n)
        s_pc_write ##1 clkEn |-> s_jump_then_dummy)
        else $error("pc write not followed by load and dummy");
    a_pc_low_loaded: assert property (@(posedge clk) disable iff (!rst_n)
        s_pc_write |=> pcLoad_q && pcLow_q == $past(acc.wdata))
        else $error("pc low byte not loaded");

    // Bank selection across resets and writes
    a_bank_reset: assert property (@(posedge clk)
        s_power_or_plain_reset |=> bankSel_q == BANK_RESET)
        else $error("bank not cleared by reset");
    a_bank_kept: assert property (@(posedge clk)
        s_sleep_dog_reset |=> $stable(bankSel_q))
        else $error("bank lost in sleep watchdog reset");
    a_bank_write_masked: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && wrBank |=> bankSel_q == ($past(acc.wdata) & bankMask))
        else $error("bank write not masked");
    a_code_bank: assert property (@(posedge clk) disable iff (!rst_n)
        s_bank_write_seen
        |=> codeBank_q == $past(acc.wdata[PBANK_LSB +: 2] & bankMask[PBANK_LSB +: 2], 2))
        else $error("program bank output wrong");

    // Address resolution, status flags, direction and control registers
    a_ptr0_addr: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && accIndirect && acc.addr == ADDR_PTR_ZERO_PORT
        |=> memSel_q.addr == $past(pointerZero_q))
        else $error("pointer zero address wrong");
    a_ptr1_addr: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && accIndirect && acc.addr == ADDR_PTR_ONE_PORT
        |=> memSel_q.addr == $past(pointerOne_q))
        else $error("pointer one address wrong");
    a_direct_addr: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && !accIndirect
        |=> memSel_q.addr == $past(acc.addr) && memSel_q.isSfr == ($past(acc.addr) < ADDR_GP_START))
        else $error("direct address resolution wrong");
    a_ptr0_bank_zero: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && accIndirect && acc.addr == ADDR_PTR_ZERO_PORT |=> memSel_q.bank == 3'd0)
        else $error("pointer zero left bank zero");
    a_ptr1_bank_sel: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && accIndirect && acc.addr == ADDR_PTR_ONE_PORT
        |=> memSel_q.bank == $past(bankSel_q[2:0]))
        else $error("pointer one bank wrong");
    a_direct_bank_zero: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && !accIndirect |=> memSel_q.bank == 3'd0)
        else $error("direct access not in bank zero");
    a_flags_protected: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && wrStatus && !dogExpiry && !dogKick && !haltExec
        |=> statusView[5:4] == $past(statusView[5:4]))
        else $error("status write changed protected flags");
    a_dog_set: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && dogExpiry ##1 clkEn |=> status_q[ST_DOG])
        else $error("dog flag not set");
    a_dog_cleared: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && (dogKick || haltExec) && !dogExpiry |=> !dogFlag_q)
        else $error("dog flag not cleared");
    a_dog_held: assert property (@(posedge clk) disable iff (!rst_n)
        !(clkEn && (dogExpiry || dogKick || haltExec)) |=> $stable(dogFlag_q))
        else $error("dog flag changed without event");
    a_sleep_cleared: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && dogKick && !haltExec |=> !sleepFlag_q)
        else $error("sleep flag not cleared");
    a_sleep_held: assert property (@(posedge clk) disable iff (!rst_n)
        !(clkEn && (haltExec || dogKick)) |=> $stable(sleepFlag_q))
        else $error("sleep flag changed without event");
    a_sleep_set: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && haltExec |=> sleepFlag_q && !dogFlag_q || $past(dogExpiry))
        else $error("halt did not set sleep flag");
    a_flags_update: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && alu.upd |=> statusFlags_q[3:0] == $past({alu.wrap, alu.zero, alu.half, alu.carry}))
        else $error("alu flags not stored");
    a_rot_carry: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && !alu.upd && alu.rot |=> statusFlags_q[ST_CARRY] == $past(alu.rotCarry)
        && statusFlags_q[ST_WRAP:ST_HALF] == $past(statusFlags_q[ST_WRAP:ST_HALF]))
        else $error("rotate did not update carry alone");
    a_sw_flags_write: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && wrStatus && !alu.upd && !alu.rot |=> statusFlags_q == $past(acc.wdata[3:0]))
        else $error("software status write lost");
    a_top_bits_zero: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && acc.rd && !accIndirect && acc.addr == ADDR_STATUS
        |=> rdata_q[7:6] == 2'b00 && status_q[7:6] == 2'b00)
        else $error("status top bits nonzero");
    a_dir_written: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && acc.wr && !accIndirect && acc.addr == ADDR_PORT_DIR ##1 clkEn
        |=> portInput_q == $past(acc.wdata, 2))
        else $error("direction register not applied");
    a_ctrl_written: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && acc.wr && !accIndirect && acc.addr == ADDR_SYS_SYSTEM_CONTROL_ZERO ##1 clkEn
        |=> sysCtrl_q == $past(acc.wdata, 2))
        else $error("control register not applied");
    a_ctrl_held: assert property (@(posedge clk) disable iff (!rst_n)
        !(clkEn && acc.wr && !accIndirect && acc.addr == ADDR_SYS_SYSTEM_CONTROL_ZERO) |=> $stable(ctrlReg_q))
        else $error("control register changed without write");
    a_regs_reset: assert property (@(posedge clk)
        !rst_n |=> ctrlReg_q == SYSTEM_CONTROL_ZERO_RESET && dirReg_q == PORT_DIR_RESET)
        else $error("control or direction not reset");

    // A low enable must hold bank, control, direction, address select, read data and pc load
    a_enable_freeze: assert property (@(posedge clk) disable iff (!rst_n)
        !clkEn |=> $stable(bankSel_q) && $stable(ctrlReg_q) && $stable(dirReg_q)
        && $stable(memSel_q) && $stable(rdata_q) && $stable(pcLoad_q))
        else $error("state moved while enable low");
endmodule : msr_core_regs

// >>> bench/msr_core_regs_tb_top.sv
// Self-checking testbench for the core special-function register bank
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD %0t got %0h exp %0h", $time, got, exp); end end
module msr_core_regs_tb_top;
    import msr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic powerUp = 1'b1;
    logic dogSleepReset = 1'b0;
    logic dogExpiry = 1'b0;
    logic dogKick = 1'b0;
    logic haltExec = 1'b0;
    msr_acc_s acc = '0;
    logic accIndirect = 1'b0;
    msr_alu_s alu = '0;
    logic [7:0] rdata_q, pcLow_q, status_q, portInput_q, sysCtrl_q, d, r, p;
    logic pcLoad_q, dummyCycle_q;
    logic [1:0] codeBank_q;
    msr_mem_s memSel_q;
    logic [7:0] rdataSmall;
    logic [1:0] codeBankSmall;
    int err_total = 0;
    int samples_checked = 0;

    msr_core_regs #(.LARGE_VARIANT(1'b1)) msr_core_regs_i (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .powerUp(powerUp), .dogSleepReset(dogSleepReset),
        .dogExpiry(dogExpiry), .dogKick(dogKick), .haltExec(haltExec), .acc(acc),
        .accIndirect(accIndirect), .alu(alu), .rdata_q(rdata_q), .pcLoad_q(pcLoad_q),
        .pcLow_q(pcLow_q), .dummyCycle_q(dummyCycle_q), .memSel_q(memSel_q),
        .codeBank_q(codeBank_q), .status_q(status_q), .portInput_q(portInput_q),
        .sysCtrl_q(sysCtrl_q));

    // Smaller variant shares all inputs; only its bank view is compared
    msr_core_regs #(.LARGE_VARIANT(1'b0)) msr_core_regs_small_i (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .powerUp(powerUp), .dogSleepReset(dogSleepReset),
        .dogExpiry(dogExpiry), .dogKick(dogKick), .haltExec(haltExec), .acc(acc),
        .accIndirect(accIndirect), .alu(alu), .rdata_q(rdataSmall), .pcLoad_q(),
        .pcLow_q(), .dummyCycle_q(), .memSel_q(), .codeBank_q(codeBankSmall),
        .status_q(), .portInput_q(), .sysCtrl_q());

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        acc <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        @(posedge clk);
        acc <= '0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic ind, output logic [7:0] v);
        @(posedge clk);
        acc <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        accIndirect <= ind;
        @(posedge clk);
        acc <= '0;
        accIndirect <= 1'b0;
        #1 v = rdata_q;
    endtask : rd

    // Registered image outputs lag a write by two edges; three leaves margin
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic ev(input logic [2:0] v);
        @(posedge clk);
        {dogExpiry, dogKick, haltExec} <= v;
        @(posedge clk);
        {dogExpiry, dogKick, haltExec} <= 3'h0;
        settle();
    endtask : ev

    task automatic do_reset(input logic pwr, input logic dsl);
        @(posedge clk);
        rst_n <= 1'b0;
        powerUp <= pwr;
        dogSleepReset <= dsl;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        powerUp <= 1'b0;
        dogSleepReset <= 1'b0;
        #1;
    endtask : do_reset

    // Flags after an update followed by a rotate that replaces only the carry
    function automatic logic [3:0] alu_nib(input msr_alu_s a, input logic c);
        return {a.wrap, a.zero, a.half, c};
    endfunction : alu_nib

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #300000;
        err_total++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'hD71F3188));
        do_reset(1'b1, 1'b0);
        `CHK(portInput_q, PORT_DIR_RESET)
        `CHK(sysCtrl_q, SYSTEM_CONTROL_ZERO_RESET)
        `CHK(status_q[7:4], 4'h0)
        rd(ADDR_BANK_SELECT, 1'b0, r);
        `CHK(r, BANK_RESET)
        rd(8'h3B, 1'b0, r);
        `CHK(r, ZERO_BYTE)
        d = 8'($urandom);
        wr(ADDR_PC_LOW, d);
        `CHK({pcLoad_q, pcLow_q}, {1'b1, d})
        @(posedge clk);
        #1 `CHK({pcLoad_q, dummyCycle_q}, 2'b01)
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'hFF : 8'($urandom);
            wr(ADDR_BANK_SELECT, d);
            settle();
            rd(ADDR_BANK_SELECT, 1'b0, r);
            `CHK(r, d & BANK_MASK_LARGE)
            `CHK(codeBank_q, d[6:5])
            `CHK(rdataSmall, d & BANK_MASK_SMALL)
            `CHK(codeBankSmall, {1'b0, d[5]})
        end
        for (int b = 0; b < 8; b++) begin
            p = 8'h80 | 8'($urandom);
            wr(ADDR_BANK_SELECT, 8'(b));
            wr(ADDR_POINTER_ONE, p);
            wr(ADDR_POINTER_ZERO, p);
            settle();
            rd(ADDR_PTR_ONE_PORT, 1'b1, r);
            `CHK(memSel_q, {3'(b), p, 1'b0})
            `CHK(r, ZERO_BYTE)
            rd(ADDR_PTR_ZERO_PORT, 1'b1, r);
            `CHK(memSel_q, {3'h0, p, 1'b0})
            rd(p, 1'b0, r);
            `CHK(memSel_q, {3'h0, p, 1'b0})
            rd(ADDR_STATUS, 1'b0, r);
            `CHK(memSel_q.isSfr, 1'b1)
        end
        wr(ADDR_STATUS, 8'hFF);
        settle();
        `CHK(status_q, 8'h0F)
        ev(3'b100);
        `CHK(status_q[5:4], 2'b10)
        wr(ADDR_STATUS, 8'h00);
        settle();
        `CHK(status_q, 8'h20)
        ev(3'b001);
        `CHK(status_q[5:4], 2'b01)
        ev(3'b100);
        `CHK(status_q[5:4], 2'b11)
        ev(3'b010);
        `CHK(status_q[5:4], 2'b00)
        ev(3'b011);
        `CHK(status_q[5:4], 2'b01)
        for (int i = 0; i < 8; i++) begin
            msr_alu_s a;
            d = 8'($urandom);
            a = '{upd: 1'b1, carry: d[0], half: d[1], wrap: d[2], zero: d[3],
                  rot: 1'b0, rotCarry: 1'b0};
            @(posedge clk);
            alu <= a;
            @(posedge clk);
            alu <= '{upd: 1'b0, carry: 1'b0, half: 1'b0, wrap: 1'b0, zero: 1'b0,
                     rot: 1'b1, rotCarry: d[4]};
            @(posedge clk);
            alu <= '0;
            settle();
            `CHK(status_q[3:0], alu_nib(a, d[4]))
        end
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            wr(ADDR_PORT_DIR, d);
            wr(ADDR_SYS_SYSTEM_CONTROL_ZERO, 8'h01 << i);
            settle();
            `CHK(portInput_q, d)
            `CHK(sysCtrl_q, 8'h01 << i)
            rd(ADDR_SYS_SYSTEM_CONTROL_ZERO, 1'b0, r);
            `CHK(r, 8'h01 << i)
        end
        @(posedge clk);
        clkEn <= 1'b0;
        wr(ADDR_SYS_SYSTEM_CONTROL_ZERO, 8'h00);
        @(posedge clk);
        clkEn <= 1'b1;
        settle();
        `CHK(sysCtrl_q, 8'h80)
        // Bank survives only a watchdog reset taken while asleep
        wr(ADDR_BANK_SELECT, 8'h05);
        ev(3'b001);
        do_reset(1'b0, 1'b1);
        rd(ADDR_BANK_SELECT, 1'b0, r);
        `CHK(r, 8'h05)
        do_reset(1'b0, 1'b0);
        rd(ADDR_BANK_SELECT, 1'b0, r);
        `CHK(r, 8'h00)
        `CHK(sysCtrl_q, SYSTEM_CONTROL_ZERO_RESET)
        ev(3'b101);
        `CHK(status_q[5:4], 2'b11)
        do_reset(1'b1, 1'b0);
        settle();
        `CHK(status_q[5:4], 2'b00)
        give_verdict();
    end
endmodule : msr_core_regs_tb_top
